// ---- logic/arc_pkg.sv ----
package arc_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_CONFIG_WORD_ZERO = 4'h0;
  localparam logic [3:0] ADDR_CONFIG_WORD_ONE = 4'h1;
  localparam logic [3:0] ADDR_MODULATOR_OUTPUT = 4'h2;
  localparam logic [3:0] ADDR_PHASE_DELAY = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_DATA_BASE = 4'h8;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SOFT_RESET_LSB = 0;
  localparam int SHUTDOWN_LSB = 0;
  localparam int EXT_REF_BIT = 4;
  localparam int EXT_CLK_BIT = 5;
  localparam int NUM_CH = 4;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] QUANT_RESET_PATTERN = 4'h3;
  localparam logic [31:0] CONFIG_ZERO_RESET = 32'h0000_0000;
  localparam logic [31:0] CONFIG_ONE_RESET = 32'h0000_0000;
  localparam logic [31:0] PHASE_RESET = 32'h0000_0000;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int SETTLE_CYCLES = 12;
  localparam int FRAME_CYCLES = 16;

  typedef struct packed {
    logic [3:0] soft_reset;
    logic [3:0] shutdown;
    logic ext_ref;
    logic ext_clk;
  } arc_ctrl_t;

  typedef enum logic [1:0] {
    CH_OFF = 2'b00,
    CH_SETTLE = 2'b01,
    CH_RUN = 2'b10
  } arc_ch_state_t;
endpackage : arc_pkg

// ---- logic/arc_top.sv ----
`timescale 1ns/1ps
module arc_top #(
  parameter int SETTLE = arc_pkg::SETTLE_CYCLES,
  parameter int FRAME = arc_pkg::FRAME_CYCLES
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RESETN,
  input wire logic I_CE,
  input wire logic [3:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [4*24-1:0] I_CONV_DATA,
  output logic [31:0] O_RDATA,
  output logic [3:0] O_DRDY,
  output logic O_CORE_CLK_EN,
  output logic O_INPUT_CLK_EN,
  output logic [3:0] O_BIAS_EN
);
  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [31:0] cfg0;
  logic [31:0] cfg1;
  logic [31:0] phase;
  logic [15:0] modout;
  arc_pkg::arc_ctrl_t ctrl;
  logic [4*24-1:0] data_q;
  arc_pkg::arc_ch_state_t st [arc_pkg::NUM_CH];
  logic [7:0] cnt [arc_pkg::NUM_CH];
  logic [7:0] frame_cnt;
  logic all_srst;
  logic all_sdn;
  logic full_sdn;

  // bit n maps to channel n
  assign ctrl.soft_reset = cfg0[arc_pkg::SOFT_RESET_LSB +: 4];
  assign ctrl.shutdown = cfg1[arc_pkg::SHUTDOWN_LSB +: 4];
  assign ctrl.ext_ref = cfg1[arc_pkg::EXT_REF_BIT];
  assign ctrl.ext_clk = cfg1[arc_pkg::EXT_CLK_BIT];
  assign all_srst = &ctrl.soft_reset;
  assign all_sdn = &ctrl.shutdown;
  assign full_sdn = all_sdn & ctrl.ext_ref & ctrl.ext_clk;

  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg0 <= arc_pkg::CONFIG_ZERO_RESET;
      cfg1 <= arc_pkg::CONFIG_ONE_RESET;
      phase <= arc_pkg::PHASE_RESET;
    end
    else if (I_CE && I_WR)
    begin
      if (I_ADDR == arc_pkg::ADDR_CONFIG_WORD_ZERO)
        cfg0 <= I_WDATA;
      if (I_ADDR == arc_pkg::ADDR_CONFIG_WORD_ONE)
        cfg1 <= I_WDATA;
      if (I_ADDR == arc_pkg::ADDR_PHASE_DELAY)
        phase <= I_WDATA;
    end
  end

  function automatic logic [31:0] rd_mux(input logic [3:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      arc_pkg::ADDR_CONFIG_WORD_ZERO: r = cfg0;
      arc_pkg::ADDR_CONFIG_WORD_ONE: r = cfg1;
      arc_pkg::ADDR_MODULATOR_OUTPUT: r = {16'h0000, modout};
      arc_pkg::ADDR_PHASE_DELAY: r = phase;
      arc_pkg::ADDR_STATUS: r = {24'h000000, st[3] == arc_pkg::CH_RUN,
        st[2] == arc_pkg::CH_RUN, st[1] == arc_pkg::CH_RUN, st[0] == arc_pkg::CH_RUN,
        O_CORE_CLK_EN, O_INPUT_CLK_EN, full_sdn, all_srst};
      4'h8: r = {8'h00, data_q[0 +: 24]};
      4'h9: r = {8'h00, data_q[24 +: 24]};
      4'ha: r = {8'h00, data_q[48 +: 24]};
      4'hb: r = {8'h00, data_q[72 +: 24]};
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction : rd_mux

  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
      O_RDATA <= 32'h0000_0000;
    else if (I_CE)
      O_RDATA <= I_RD ? rd_mux(I_ADDR) : 32'h0000_0000;
  end

  // ---------------------------------------------------------------
  // shared frame timebase
  // ---------------------------------------------------------------
  // free running unless all channels in soft reset or all shut down, so exits realign to it
  // timebase survives single channel reset
  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
      frame_cnt <= 8'h00;
    else if (I_CE && O_CORE_CLK_EN)
      frame_cnt <= (frame_cnt == 8'(FRAME - 1)) ? 8'h00 : frame_cnt + 8'h01;
  end

  // ---------------------------------------------------------------
  // per-channel state
  // ---------------------------------------------------------------
  for (genvar n = 0; n < arc_pkg::NUM_CH; n++)
  begin : g_ch
    logic idle;
    logic frame_hit;
    assign idle = ctrl.soft_reset[n] | ctrl.shutdown[n];
    assign frame_hit = frame_cnt == (8'(phase[n*8 +: 8]) % 8'(FRAME));

    always_ff @(posedge I_SYS_CLK or negedge rst_n)
    begin
      if (!rst_n)
      begin
        st[n] <= arc_pkg::CH_OFF;
        cnt[n] <= 8'h00;
      end
      else if (I_CE)
      begin
        unique case (st[n])
          arc_pkg::CH_OFF:
          begin
            cnt[n] <= 8'h00;
            if (!idle)
              st[n] <= arc_pkg::CH_SETTLE;
          end
          arc_pkg::CH_SETTLE:
          begin
            // settle then run, no extra delay
            if (idle)
              st[n] <= arc_pkg::CH_OFF;
            else if (cnt[n] == 8'(SETTLE - 1))
              st[n] <= arc_pkg::CH_RUN;
            else
              cnt[n] <= cnt[n] + 8'h01;
          end
          arc_pkg::CH_RUN:
            if (idle)
              st[n] <= arc_pkg::CH_OFF;
          default:
            st[n] <= arc_pkg::CH_OFF;
        endcase
      end
    end

    always_ff @(posedge I_SYS_CLK or negedge rst_n)
    begin
      if (!rst_n)
        data_q[n*24 +: 24] <= 24'h000000;
      else if (I_CE)
      begin
        if (idle)
          data_q[n*24 +: 24] <= 24'h000000;
        else if (st[n] == arc_pkg::CH_RUN && frame_hit)
          data_q[n*24 +: 24] <= I_CONV_DATA[n*24 +: 24];
      end
    end

    always_ff @(posedge I_SYS_CLK or negedge rst_n)
    begin
      if (!rst_n)
        O_DRDY[n] <= 1'b0;
      else if (I_CE)
        O_DRDY[n] <= !idle && st[n] == arc_pkg::CH_RUN && frame_hit;
    end

    always_ff @(posedge I_SYS_CLK or negedge rst_n)
    begin
      if (!rst_n)
        modout[n*4 +: 4] <= arc_pkg::QUANT_RESET_PATTERN;
      else if (I_CE && ctrl.soft_reset[n])
        modout[n*4 +: 4] <= arc_pkg::QUANT_RESET_PATTERN;
    end

    always_ff @(posedge I_SYS_CLK or negedge rst_n)
    begin
      if (!rst_n)
        O_BIAS_EN[n] <= 1'b1;
      else if (I_CE)
        O_BIAS_EN[n] <= !ctrl.shutdown[n];
    end
  end

  // ---------------------------------------------------------------
  // clock gating
  // ---------------------------------------------------------------
  // enables stand in for gates; a real cell would sit outside
  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      O_CORE_CLK_EN <= 1'b1;
      O_INPUT_CLK_EN <= 1'b1;
    end
    else if (I_CE)
    begin
      // core clock off when all reset
      // core off when all shut down
      O_CORE_CLK_EN <= !(all_srst || all_sdn || full_sdn);
      // inputs clocked in all soft reset
      O_INPUT_CLK_EN <= !(all_sdn || full_sdn);
    end
  end
endmodule : arc_top

// ---- tb/adc_reset_shutdown_control_tb_top.sv ----
`timescale 1ns/1ps
module adc_reset_shutdown_control_tb_top;
  localparam int ST = 5;
  localparam int FR = 10;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic [95:0] conv = '0;
  logic [3:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic wr;
  logic rd;
  logic [3:0] drdy;
  logic [3:0] bias;
  logic cke;
  logic ike;
  logic [31:0] seed = 32'h0000_601d;
  logic [31:0] d;
  logic [31:0] phw;
  int n_checks = 0;
  int fail_count = 0;
  int t[4];
  int c[4];
  int ph[4];
  initial forever #10 clk = ~clk;
  arc_top #(.SETTLE(ST), .FRAME(FR)) i_dut (.I_SYS_CLK(clk), .I_RESETN(rstn), .I_CE(ce),
    .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .I_CONV_DATA(conv), .O_RDATA(rdata),
    .O_DRDY(drdy), .O_CORE_CLK_EN(cke), .O_INPUT_CLK_EN(ike), .O_BIAS_EN(bias));
  arc_host_model i_host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
    .o_wr(wr), .o_rd(rd));
  // --------
  // helpers
  // --------
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic int md(input int x);
    return ((x % FR) + FR) % FR;
  endfunction : md
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  // last pulse per channel wins, so early results are dropped
  task automatic watch(input int n);
    for (int i = 0; i < 4; i++)
    begin
      t[i] = -1;
      c[i] = 0;
    end
    for (int k = 0; k < n; k++)
    begin
      @(posedge clk);
      for (int i = 0; i < 4; i++)
        if (drdy[i] === 1'b1)
        begin
          t[i] = k;
          c[i]++;
        end
    end
  endtask : watch
  task automatic run_chk(input logic [3:0] idle);
    int r;
    watch(3 * FR);
    r = 0;
    for (int i = 3; i >= 0; i--)
      if (!idle[i])
        r = i;
    for (int i = 0; i < 4; i++)
    begin
      i_host.rd(arc_pkg::ADDR_DATA_BASE + i[3:0], d);
      chk(d, idle[i] ? 32'h0 : {8'h00, conv[i*24+:24]});
      chk(c[i], idle[i] ? 0 : 3);
      if (!idle[i])
        chk(md(t[i] - t[r]), md(ph[i] - ph[r]));
    end
  endtask : run_chk
  task automatic regs_chk();
    for (int a = 8; a >= 0; a--)
      if (a != 4)
      begin
        i_host.rd(a[3:0], d);
        chk(d, a == 2 ? 32'h0000_3333 : 32'h0);
      end
  endtask : regs_chk
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
  // --------
  // main sequence
  // --------
  initial
  begin
    int ch;
    logic [3:0] m;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    conv <= {rnd(), rnd(), rnd()};
    repeat (2) @(posedge clk);
    regs_chk();
    chk({bias, ike, cke}, 32'h3f);
    i_host.wr(4'h5, rnd());
    i_host.rd(4'h5, d);
    chk(d, 32'h0);
    for (int i = 0; i < 4; i++)
      ph[i] = rnd() % FR;
    phw = {ph[3][7:0], ph[2][7:0], ph[1][7:0], ph[0][7:0]};
    i_host.wr(arc_pkg::ADDR_PHASE_DELAY, phw);
    watch(ST + 2 * FR);
    run_chk(4'h0);
    for (int j = 0; j < 4; j++)
    begin
      ch = rnd() % 4;
      m = j[1] ? 4'hf : 4'h1 << ch;
      i_host.wr(j[0] ? 4'h1 : 4'h0, (j == 3) ? 32'h3f : {28'h0, m});
      repeat (FR) @(posedge clk);
      chk({ike, cke}, j[1] ? (j[0] ? 32'h0 : 32'h2) : 32'h3);
      chk(bias, {28'h0, j[0] ? ~m : 4'hf});
      i_host.rd(arc_pkg::ADDR_STATUS, d);
      chk(d, {24'h0, ~m, j[1] ? (j[0] ? 4'h2 : 4'h5) : 4'hc});
      run_chk(m);
      i_host.rd(arc_pkg::ADDR_MODULATOR_OUTPUT, d);
      if (!j[0])
        chk(d[4*ch+:4], 32'h3);
      i_host.rd(arc_pkg::ADDR_PHASE_DELAY, d);
      chk(d, phw);
      i_host.wr(j[0] ? 4'h1 : 4'h0, 32'h0);
      watch(ST + 2 * FR);
      run_chk(4'h0);
    end
    i_host.wr(arc_pkg::ADDR_CONFIG_WORD_ZERO, 32'h5);
    rstn <= 1'b0;
    // host breaks the quiet period on purpose; the write must vanish
    i_host.wr(arc_pkg::ADDR_CONFIG_WORD_ONE, 32'hf);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    regs_chk();
    wrap_up();
  end
endmodule : adc_reset_shutdown_control_tb_top

// ---- tb/arc_host_model.sv ----
`timescale 1ns/1ps
module arc_host_model (
  input wire logic i_clk,
  input wire logic [31:0] i_rdata,
  output logic [3:0] o_addr = 4'h0,
  output logic [31:0] o_wdata = 32'h0,
  output logic o_wr = 1'b0,
  output logic o_rd = 1'b0
);
  // --------
  // register bus master
  // --------
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= v;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
  endtask : wr
  // data sampled before that edge updates it
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    @(posedge i_clk);
    v = i_rdata;
  endtask : rd
endmodule : arc_host_model

// ---- tb/arc_monitor.sv ----
`timescale 1ns/1ps
module arc_monitor (
  input wire logic I_SYS_CLK,
  input wire logic I_RESETN,
  input wire logic I_CE,
  input wire logic [3:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic [3:0] O_DRDY,
  input wire logic O_CORE_CLK_EN,
  input wire logic O_INPUT_CLK_EN,
  input wire logic [3:0] O_BIAS_EN
);
  // --------
  // shadow of control fields
  // --------
  logic [3:0] sr;
  logic [3:0] sd;
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      sr <= 4'h0;
      sd <= 4'h0;
    end
    else if (I_CE && I_WR)
    begin
      if (I_ADDR == arc_pkg::ADDR_CONFIG_WORD_ZERO)
        sr <= I_WDATA[3:0];
      if (I_ADDR == arc_pkg::ADDR_CONFIG_WORD_ONE)
        sd <= I_WDATA[3:0];
    end
  end
  default clocking dc @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RESETN);
  // depth 3 leaves room for a pulse already in flight
  drdy_pulse_a: assert property ((O_DRDY & $past(O_DRDY)) == 4'h0) else $error("long drdy");
  reset_quiet_a: assert property ((O_DRDY & sr & $past(sr, 3)) == 4'h0) else $error("drdy in reset");
  shut_quiet_a: assert property ((O_DRDY & sd & $past(sd, 3)) == 4'h0) else $error("drdy in shutdown");
  bias_follow_a: assert property ($changed(sd) |-> ##[1:4] O_BIAS_EN == ~sd) else $error("bias");
  core_gate_a: assert property ($rose(&sr) |-> ##[1:4] !O_CORE_CLK_EN) else $error("core on");
  core_back_a: assert property ($fell(&sr) && !(&sd) |-> ##[1:4] O_CORE_CLK_EN) else $error("core off");
  input_keep_a: assert property ((&sr && !(&sd)) [*6] |-> O_INPUT_CLK_EN) else $error("input off");
  all_off_a: assert property ((&sd) [*6] |-> !O_INPUT_CLK_EN && !O_CORE_CLK_EN) else $error("clk on");
  one_idle_a: assert property ((!(&sr) && !(&sd)) [*6] |-> O_CORE_CLK_EN) else $error("clk stop");
  cover property ($rose(&sr));
  cover property ($rose(&sd));
  cover property (O_DRDY[0]);
endmodule : arc_monitor
bind arc_top arc_monitor i_mon (.I_SYS_CLK(I_SYS_CLK), .I_RESETN(I_RESETN), .I_CE(I_CE),
  .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .O_DRDY(O_DRDY),
  .O_CORE_CLK_EN(O_CORE_CLK_EN), .O_INPUT_CLK_EN(O_INPUT_CLK_EN), .O_BIAS_EN(O_BIAS_EN));
